// >>> dv/irq_src_model.sv
/*
 * partner model: external interrupt sources on the port 0 pins
 * assumes: the bench calls its tasks just after a rising edge of pclk
 */
`timescale 1ns/10ps
module irq_src_model (
    input  wire logic       pclk,
    input  wire logic       ack,
    output logic      [7:0] pins
);
    logic [7:0] lvl_q  = 8'hff;
    logic       hold_q = 1'b0;
    int         idx    = 0;

    // pins are only ever driven by the sources, never by the block
    assign pins = lvl_q;

    // plain sources: a new level lands at this edge and is kept
    task automatic set_pins(input logic [7:0] v);
        lvl_q <= v;
    endtask

    // level request, held until the core has recognised it
    task automatic request(input int i);
        idx = i;
        hold_q   <= 1'b1;
        lvl_q[i] <= 1'b1;
    endtask

    // withdraw at the recognition, well before the routine could end
    always @(posedge pclk) begin
        if (hold_q && ack) begin
            lvl_q[idx] <= 1'b0;
            hold_q     <= 1'b0;
        end
    end
endmodule

// >>> dv/tb.sv
/*
 * self-checking bench for the external interrupt block
 * assumes: design and params header compiled first, apb byte addresses
 */
`timescale 1ns/10ps
`include "ext_irq_params.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module tb;
    import ext_irq_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        rerr, en0, en1, ack0, ack1, pm_ev, rg_ev;
    logic        req0, req1, pm_req, pm_hi, rg_req, rg_hi, irq;
    logic [7:0]  pins;
    logic        clk_en;
    logic [3:0]  pstrb;
    int          bad_count       = 0;
    int          samples_checked = 0;

    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    ext_irq_ctrl ext_irq_ctrl_i (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port0_pins(pins),
        .ext_irq0_enable(en0), .ext_irq1_enable(en1),
        .ext_irq0_vector_ack(ack0), .ext_irq1_vector_ack(ack1),
        .port_match_event(pm_ev), .regulator_dropout_event(rg_ev),
        .ext_irq0_req(req0), .ext_irq1_req(req1),
        .port_match_req(pm_req), .port_match_req_high(pm_hi),
        .regulator_req(rg_req), .regulator_req_high(rg_hi), .irq(irq)
    );

    irq_src_model irq_src_model_i (.pclk(pclk), .ack(ack0), .pins(pins));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; waits for pready under a bound, then releases
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count++;
            end_sim();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e);
    endtask

    // reset values, unused bits, priority and enable gating
    task automatic t_regs;
        rd(`ADDR_PIN_POL_CFG, 32'h01);
        rd(`ADDR_ENABLE_SECOND, 32'h00);
        rd(`ADDR_PRIO_SECOND, 32'h00);
        rd(`ADDR_TIMER_CTRL, 32'h00);
        apb(1'b0, 12'h200, 32'h0);
        `CHK(rerr, 1'b1);
        `CHK(rdat, 32'h0);
        wr(`ADDR_ENABLE_SECOND, 32'hff);
        rd(`ADDR_ENABLE_SECOND, 32'h03);
        wr(`ADDR_PRIO_SECOND, 32'hfe);
        rd(`ADDR_PRIO_SECOND, 32'h02);
        `CHK({pm_hi, rg_hi}, 2'b10);
        wr(`ADDR_PRIO_SECOND, 32'h01);
        ticks(2);
        `CHK({pm_hi, rg_hi}, 2'b01);
        wr(`ADDR_ENABLE_SECOND, 32'h02);
        pm_ev <= 1'b1;
        rg_ev <= 1'b1;
        ticks(3);
        `CHK({pm_req, rg_req}, 2'b10);
        wr(`ADDR_ENABLE_SECOND, 32'h01);
        ticks(2);
        `CHK({pm_req, rg_req, rg_hi}, 3'b011);
        pm_ev <= 1'b0;
        rg_ev <= 1'b0;
        ticks(2);
    endtask

    // sticky status, mask and the summary interrupt
    task automatic t_irq;
        wr(`ADDR_IRQ_STATUS, 32'h0f);
        rd(`ADDR_IRQ_STATUS, 32'h00);
        pm_ev <= 1'b1;
        ticks(2);
        pm_ev <= 1'b0;
        rd(`ADDR_IRQ_STATUS, 32'h04);
        `CHK(irq, 1'b0);
        wr(`ADDR_IRQ_MASK, 32'h04);
        ticks(2);
        `CHK(irq, 1'b1);
        wr(`ADDR_IRQ_STATUS, 32'h04);
        ticks(2);
        `CHK(irq, 1'b0);
        rd(`ADDR_IRQ_STATUS, 32'h00);
    endtask

    // every pin code, both polarities, level mode on both inputs
    task automatic t_pins;
        logic [7:0] c;
        wr(`ADDR_TIMER_CTRL, 32'h00);
        for (int p = 0; p < 8; p++) begin
            c = {1'b1, 3'(p), 1'b1, 3'(p)};
            wr(`ADDR_PIN_POL_CFG, 32'(c));
            rd(`ADDR_PIN_POL_CFG, 32'(c));
            irq_src_model_i.set_pins(8'h01 << p);
            ticks(5);
            rd(`ADDR_TIMER_CTRL, 32'h0a);
            c = c & 8'h77;
            wr(`ADDR_PIN_POL_CFG, 32'(c));
            irq_src_model_i.set_pins(~(8'h01 << p));
            ticks(5);
            rd(`ADDR_TIMER_CTRL, 32'h0a);
            irq_src_model_i.set_pins(8'hff);
            ticks(5);
            rd(`ADDR_TIMER_CTRL, 32'h00);
        end
    endtask

    // edge mode: set on activation, kept, cleared by the vector ack
    task automatic t_edge;
        irq_src_model_i.set_pins(8'h04);
        wr(`ADDR_PIN_POL_CFG, 32'hd2);
        wr(`ADDR_TIMER_CTRL, 32'h05);
        ticks(5);
        wr(`ADDR_TIMER_CTRL, 32'h05);
        rd(`ADDR_TIMER_CTRL, 32'h05);
        en0 <= 1'b1;
        en1 <= 1'b1;
        irq_src_model_i.set_pins(8'h20);
        ticks(5);
        rd(`ADDR_TIMER_CTRL, 32'h0f);
        `CHK({req0, req1}, 2'b11);
        irq_src_model_i.set_pins(8'h04);
        ticks(5);
        rd(`ADDR_TIMER_CTRL, 32'h0f);
        ack0 <= 1'b1;
        ticks(1);
        ack0 <= 1'b0;
        ticks(3);
        rd(`ADDR_TIMER_CTRL, 32'h0d);
        ack1 <= 1'b1;
        ticks(1);
        ack1 <= 1'b0;
        ticks(3);
        rd(`ADDR_TIMER_CTRL, 32'h05);
        `CHK({req0, req1}, 2'b00);
    endtask

    // level source held until the ack, then withdrawn by the source
    task automatic t_level;
        wr(`ADDR_TIMER_CTRL, 32'h00);
        wr(`ADDR_PIN_POL_CFG, 32'h0e);
        irq_src_model_i.set_pins(8'h01);
        ticks(5);
        irq_src_model_i.request(6);
        ticks(8);
        `CHK({req0, req1}, 2'b10);
        en0 <= 1'b0;
        ticks(2);
        `CHK(req0, 1'b0);
        en0 <= 1'b1;
        ticks(2);
        ack0 <= 1'b1;
        ticks(1);
        ack0 <= 1'b0;
        ticks(6);
        `CHK(req0, 1'b0);
        rd(`ADDR_TIMER_CTRL, 32'h00);
    endtask

    // clock enable freezes all state; only byte lane 0 carries writes
    task automatic t_gate;
        clk_en <= 1'b0;
        irq_src_model_i.set_pins(8'h40);
        ticks(6);
        `CHK({req0, req1}, 2'b00);
        clk_en <= 1'b1;
        ticks(6);
        `CHK({req0, req1}, 2'b11);
        rd(`ADDR_SRC_STATUS, 32'h03);
        pstrb <= 4'he;
        wr(`ADDR_PIN_POL_CFG, 32'h88);
        pstrb <= 4'hf;
        rd(`ADDR_PIN_POL_CFG, 32'h0e);
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        en0     = 1'b0;
        en1     = 1'b0;
        ack0    = 1'b0;
        ack1    = 1'b0;
        pm_ev   = 1'b0;
        rg_ev   = 1'b0;
        clk_en  = 1'b1;
        pstrb   = 4'hf;
        ticks(5);
        presetn <= 1'b1;
        ticks(1);
        t_regs();
        t_irq();
        t_pins();
        t_edge();
        t_level();
        t_gate();
        end_sim();
    end

    // watchdog cuts a hang short
    initial begin
        ticks(20000);
        bad_count++;
        end_sim();
    end
endmodule

// >>> src/ext_irq_ctrl.sv
/*
 * external interrupt configuration and detection, second extended
 * enable/priority registers, apb slave and summary interrupt
 * assumes: apb master in pclk domain, port 0 pins synchronous enough
 * to pass a two-flop synchroniser, core gives a one-cycle vector ack
 */
// The APB interface to the registers was left to the implementer.
//
// Functional notes
// - enable bit 1 gates the port-match interrupt to the core
// - enable bit 0 gates the regulator dropout interrupt
// - bits 7..2 of enable and priority read zero, ignore writes
// - priority bit 1 gives port-match low (0) or high (1) level
// - priority bit 0 gives regulator low (0) or high (1) level
// - trigger bit 1 edge, 0 level; polarity 0 low, 1 high
// - config bit 7 is polarity of external interrupt 1
// - config bit 3 is polarity of external interrupt 0
// - config bits 6..4 pick port 0 pin for interrupt 1
// - config bits 2..0 pick port 0 pin for interrupt 0
// - pins sampled read-only, independent of crossbar routing
// - pending flags are timer control bits 1 and 3
// - edge pending flag cleared by hardware on core vector
// - level pending flag follows the active pin level
`timescale 1ns/10ps
`include "ext_irq_params.svh"
module ext_irq_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  port0_pins,
    input  wire logic        ext_irq0_enable,
    input  wire logic        ext_irq1_enable,
    input  wire logic        ext_irq0_vector_ack,
    input  wire logic        ext_irq1_vector_ack,
    input  wire logic        port_match_event,
    input  wire logic        regulator_dropout_event,
    output logic             ext_irq0_req,
    output logic             ext_irq1_req,
    output logic             port_match_req,
    output logic             port_match_req_high,
    output logic             regulator_req,
    output logic             regulator_req_high,
    output logic             irq
);
    import ext_irq_pkg::*;

    byte_t            cfg_q;
    byte_t            en2_q;
    byte_t            pri2_q;
    logic             it0_q;
    logic             it1_q;
    logic             pend0_q;
    logic             pend1_q;
    logic [3:0]       sts_q;
    logic [3:0]       msk_q;
    apb_phase_e       phase_q;
    logic [7:0]       pins_s;
    logic             act0;
    logic             act1;
    logic             rise0;
    logic             rise1;
    logic             wr_fire;
    logic             rd_fire;
    logic             unmapped;
    logic             pend0_d;
    logic             pend1_d;
    byte_t            timer_control_reg_rd;
    logic [31:0]      rd_d;
    logic [3:0]       sts_set;

    ext_irq_sync #(.WIDTH(8)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .din     (port0_pins),
        .dout    (pins_s)
    );

    ext_irq_detect u_det0 (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .pins       (pins_s),
        .pin_select (cfg_q[`LSB_IRQ0_SEL +: 3]),
        .polarity   (cfg_q[`BIT_IRQ0_POL]),
        .active     (act0),
        .rise       (rise0)
    );

    ext_irq_detect u_det1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .pins       (pins_s),
        .pin_select (cfg_q[`LSB_IRQ1_SEL +: 3]),
        .polarity   (cfg_q[`BIT_IRQ1_POL]),
        .active     (act1),
        .rise       (rise1)
    );

    // bus phase seen at the last edge; pready may only stand in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= apb_idle;
        end else if (clk_en) begin
            if (!psel) begin
                phase_q <= apb_idle;
            end else if (!penable) begin
                phase_q <= apb_setup;
            end else begin
                phase_q <= apb_access;
            end
        end
    end

    // pready is registered: one wait state, so outputs stay flopped
    assign wr_fire = clk_en & psel & penable & pready & pwrite;
    assign rd_fire = clk_en & psel & penable & ~pready & ~pwrite;

    always_comb begin
        unmapped = 1'b1;
        case (paddr)
            `ADDR_PIN_POL_CFG, `ADDR_ENABLE_SECOND, `ADDR_PRIO_SECOND,
            `ADDR_TIMER_CTRL, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK,
            `ADDR_SRC_STATUS: unmapped = 1'b0;
            default:          unmapped = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & unmapped;
        end
    end

    // timer control readback: only trigger and pending bits live here
    always_comb begin
        timer_control_reg_rd = 8'h00;
        timer_control_reg_rd[`BIT_IRQ0_TRIG] = it0_q;
        timer_control_reg_rd[`BIT_IRQ0_PEND] = pend0_q;
        timer_control_reg_rd[`BIT_IRQ1_TRIG] = it1_q;
        timer_control_reg_rd[`BIT_IRQ1_PEND] = pend1_q;
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `ADDR_PIN_POL_CFG:   rd_d[7:0] = cfg_q;
            `ADDR_ENABLE_SECOND: rd_d[7:0] = en2_q & `SECOND_USED_MASK;
            `ADDR_PRIO_SECOND:   rd_d[7:0] = pri2_q & `SECOND_USED_MASK;
            `ADDR_TIMER_CTRL:    rd_d[7:0] = timer_control_reg_rd;
            `ADDR_IRQ_STATUS:    rd_d[3:0] = sts_q;
            `ADDR_IRQ_MASK:      rd_d[3:0] = msk_q;
            `ADDR_SRC_STATUS:    rd_d[1:0] = {act1, act0};
            default:             rd_d = 32'h0000_0000;
        endcase
    end

    // read data captured in the first access cycle, held for the ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            prdata <= rd_d;
        end
    end

    // configuration register writes; only byte lane 0 is used
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= `RST_PIN_POL_CFG;
            en2_q  <= `RST_ENABLE_SECOND;
            pri2_q <= `RST_PRIO_SECOND;
            it0_q  <= 1'b0;
            it1_q  <= 1'b0;
            msk_q  <= 4'h0;
        end else if (wr_fire && pstrb[0]) begin
            case (paddr)
                `ADDR_PIN_POL_CFG:   cfg_q <= pwdata[7:0];
                `ADDR_ENABLE_SECOND:
                    en2_q <= pwdata[7:0] & `SECOND_USED_MASK;
                `ADDR_PRIO_SECOND:
                    pri2_q <= pwdata[7:0] & `SECOND_USED_MASK;
                `ADDR_TIMER_CTRL: begin
                    it0_q <= pwdata[`BIT_IRQ0_TRIG];
                    it1_q <= pwdata[`BIT_IRQ1_TRIG];
                end
                `ADDR_IRQ_MASK:      msk_q <= pwdata[3:0];
                default:             msk_q <= msk_q;
            endcase
        end
    end

    // pending flags: edge sets win over vector ack and software writes
    always_comb begin
        pend0_d = pend0_q;
        pend1_d = pend1_q;
        if (wr_fire && pstrb[0] && paddr == `ADDR_TIMER_CTRL) begin
            pend0_d = pwdata[`BIT_IRQ0_PEND];
            pend1_d = pwdata[`BIT_IRQ1_PEND];
        end
        if (ext_irq0_vector_ack) begin
            pend0_d = 1'b0;
        end
        if (ext_irq1_vector_ack) begin
            pend1_d = 1'b0;
        end
        if (rise0) begin
            pend0_d = 1'b1;
        end
        if (rise1) begin
            pend1_d = 1'b1;
        end
        if (!it0_q) begin
            pend0_d = act0;
        end
        if (!it1_q) begin
            pend1_d = act1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend0_q <= 1'b0;
            pend1_q <= 1'b0;
        end else if (clk_en) begin
            pend0_q <= pend0_d;
            pend1_q <= pend1_d;
        end
    end

    // sticky status: ext0, ext1, port match, regulator; w1c, set wins
    assign sts_set = {regulator_dropout_event, port_match_event,
                      pend1_q, pend0_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= 4'h0;
        end else if (clk_en) begin
            if (wr_fire && pstrb[0] && paddr == `ADDR_IRQ_STATUS) begin
                sts_q <= (sts_q & ~pwdata[3:0]) | sts_set;
            end else begin
                sts_q <= sts_q | sts_set;
            end
        end
    end

    // core requests, flopped so every output comes from a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq0_req        <= 1'b0;
            ext_irq1_req        <= 1'b0;
            port_match_req      <= 1'b0;
            port_match_req_high <= 1'b0;
            regulator_req       <= 1'b0;
            regulator_req_high  <= 1'b0;
            irq                 <= 1'b0;
        end else if (clk_en) begin
            ext_irq0_req   <= pend0_d & ext_irq0_enable;
            ext_irq1_req   <= pend1_d & ext_irq1_enable;
            port_match_req <= port_match_event & en2_q[`BIT_PMATCH];
            port_match_req_high <= pri2_q[`BIT_PMATCH];
            regulator_req  <= regulator_dropout_event
                              & en2_q[`BIT_REGDROP];
            regulator_req_high  <= pri2_q[`BIT_REGDROP];
            irq <= |(sts_q & msk_q);
        end
    end

    // assertions
    property p_en2_rsvd;
        @(posedge pclk) disable iff (!presetn)
        en2_q[7:2] == 6'h00 && pri2_q[7:2] == 6'h00;
    endproperty
    a_en2_rsvd: assert property (p_en2_rsvd)
        else $error("reserved enable or priority bits set");

    property p_pm_mask;
        @(posedge pclk) disable iff (!presetn)
        clk_en && !en2_q[`BIT_PMATCH] |=> !port_match_req;
    endproperty
    a_pm_mask: assert property (p_pm_mask)
        else $error("port match request while disabled");

    property p_reg_pass;
        @(posedge pclk) disable iff (!presetn)
        clk_en && en2_q[`BIT_REGDROP] && regulator_dropout_event
        |=> regulator_req;
    endproperty
    a_reg_pass: assert property (p_reg_pass)
        else $error("regulator request missing");

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> port_match_req_high == $past(pri2_q[`BIT_PMATCH])
               && regulator_req_high == $past(pri2_q[`BIT_REGDROP]);
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority not forwarded");

    property p_level0;
        @(posedge pclk) disable iff (!presetn)
        clk_en && !it0_q |=> pend0_q == $past(act0);
    endproperty
    a_level0: assert property (p_level0)
        else $error("level pending does not follow input");

    property p_edge_set;
        @(posedge pclk) disable iff (!presetn)
        clk_en && it1_q && rise1 |=> pend1_q;
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("edge not captured");

    property p_ack_clr;
        @(posedge pclk) disable iff (!presetn)
        clk_en && it0_q && ext_irq0_vector_ack && !rise0 |=> !pend0_q;
    endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("vector ack did not clear pending");

    property p_req0;
        @(posedge pclk) disable iff (!presetn)
        $past(clk_en) && ext_irq0_req |-> $past(ext_irq0_enable);
    endproperty
    a_req0: assert property (p_req0)
        else $error("request without enable");

    property p_irq_out;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> irq == |($past(sts_q) & $past(msk_q));
    endproperty
    a_irq_out: assert property (p_irq_out)
        else $error("summary interrupt wrong");

    property p_ready_phase;
        @(posedge pclk) disable iff (!presetn)
        pready |-> phase_q == apb_access;
    endproperty
    a_ready_phase: assert property (p_ready_phase)
        else $error("ready outside an access phase");

    c_edge0: cover property (@(posedge pclk) disable iff (!presetn)
        it0_q && rise0 ##1 pend0_q);
    c_ack: cover property (@(posedge pclk) disable iff (!presetn)
        pend1_q && ext_irq1_vector_ack);
    c_pm: cover property (@(posedge pclk) disable iff (!presetn)
        port_match_req && port_match_req_high);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

// >>> src/ext_irq_detect.sv
/*
 * one external interrupt channel: pin select, polarity, edge detect
 * assumes: pins already synchronised to pclk
 */
`timescale 1ns/10ps
module ext_irq_detect (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    input  wire logic [7:0] pins,
    input  wire logic [2:0] pin_select,
    input  wire logic       polarity,
    output logic            active,
    output logic            rise
);
    logic prev_q;

    // selected pin is only read, never driven: no crossbar disturbance
    assign active = pins[pin_select] ~^ polarity;
    assign rise   = active & ~prev_q;

    // previous active level; resets as active so that reset gives no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b1;
        end else if (clk_en) begin
            prev_q <= active;
        end
    end
endmodule

// >>> src/ext_irq_params.svh
/*
 * constants for the external interrupt and second extended
 * enable/priority block: register offsets, field positions, reset values
 * assumes: included by its bare name from the bench and the ext_irq_ctrl design file
 */
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

// register indexes; some are odd, so each register gets a word of its own
`define OFF_PIN_POL_CFG    12'h0e4
`define OFF_ENABLE_SECOND  12'h0e7
`define OFF_PRIO_SECOND    12'h0f7
`define OFF_TIMER_CTRL     12'h088
`define OFF_IRQ_STATUS     12'h040
`define OFF_IRQ_MASK       12'h041
`define OFF_SRC_STATUS     12'h042

// byte addresses on the apb bus: four times the register index
`define ADDR_PIN_POL_CFG   12'h390
`define ADDR_ENABLE_SECOND 12'h39c
`define ADDR_PRIO_SECOND   12'h3dc
`define ADDR_TIMER_CTRL    12'h220
`define ADDR_IRQ_STATUS    12'h100
`define ADDR_IRQ_MASK      12'h104
`define ADDR_SRC_STATUS    12'h108

// reset values
`define RST_PIN_POL_CFG    8'h01
`define RST_ENABLE_SECOND  8'h00
`define RST_PRIO_SECOND    8'h00
`define RST_TIMER_CTRL     8'h00

// field positions
`define BIT_IRQ1_POL       7
`define BIT_IRQ0_POL       3
`define LSB_IRQ1_SEL       4
`define LSB_IRQ0_SEL       0
`define BIT_IRQ1_PEND      3
`define BIT_IRQ1_TRIG      2
`define BIT_IRQ0_PEND      1
`define BIT_IRQ0_TRIG      0
`define BIT_PMATCH         1
`define BIT_REGDROP        0
`define SECOND_USED_MASK   8'h03

`endif

// >>> src/ext_irq_pkg.sv
/*
 * types shared by the external interrupt block
 * assumes: nothing beyond the params header
 */
package ext_irq_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] pin_sel_t;
    typedef enum logic [1:0] {
        apb_idle,
        apb_setup,
        apb_access
    } apb_phase_e;
endpackage

// >>> src/ext_irq_sync.sv
/*
 * two-flop synchroniser for a bus of port pins
 * assumes: single clock, clock enable freezes the flops
 */
`timescale 1ns/10ps
module ext_irq_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // first flop only feeds the second one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout   <= '0;
        end else if (clk_en) begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
